/* common/cc_pkg.sv */
package cc_pkg;
  // clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TIME_TICK_NS = 878_900_000;
  localparam int unsigned TIME_TICK_CYCLES = TIME_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned OFS_LSB_NS = 9_760_000;
  localparam int unsigned OFS_LSB_CYCLES = OFS_LSB_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 25;
  localparam int OFS_PRE_W = 18;
  localparam int OFS_W = 22;
  // wide enough for the slowest rate at 0 C, eight hours of ticks
  localparam int SD_PRE_W = 16;
  // time ticks per hour of self-discharge at the base temperature
  localparam logic [SD_PRE_W-1:0] SD_TICKS_PER_HOUR = 16'h1000;
  // slow-rate divider: one count per 256 time ticks
  localparam logic [7:0] SLOW_PRE_LAST = 8'hff;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // temperature steps for the self-discharge rate
  localparam logic [9:0] KELVIN_ZERO_C = 10'h111;
  localparam int SD_BASE_C = 25;
  localparam int SD_STEP_C = 10;
  localparam int SD_HIGH_C = 60;
  localparam int SD_LOW_C = 0;
  // register addresses on the serial link
  localparam logic [6:0] ADDR_OFS_HI = 7'h77;
  localparam logic [6:0] ADDR_OFS_MID = 7'h76;
  localparam logic [6:0] ADDR_OFS_LO = 7'h75;
  localparam logic [6:0] ADDR_DSG_H = 7'h6e;
  localparam logic [6:0] ADDR_DSG_L = 7'h6d;
  localparam logic [6:0] ADDR_CHG_H = 7'h6c;
  localparam logic [6:0] ADDR_CHG_L = 7'h6b;
  localparam logic [6:0] ADDR_SD_H = 7'h6a;
  localparam logic [6:0] ADDR_SD_L = 7'h69;
  localparam logic [6:0] ADDR_DT_H = 7'h68;
  localparam logic [6:0] ADDR_DT_L = 7'h67;
  localparam logic [6:0] ADDR_CT_H = 7'h66;
  localparam logic [6:0] ADDR_CT_L = 7'h65;
  localparam logic [6:0] ADDR_MODE = 7'h64;
  localparam logic [6:0] ADDR_CLR = 7'h63;
  localparam logic [6:0] ADDR_CMD = 7'h62;
  // offset high byte fields
  localparam int OFS_OFFSET_COMP_ENABLE_BIT = 7;
  localparam int OFS_DIR_BIT = 6;
  // mode_wake_register fields
  localparam int MODE_REGDIS_BIT = 7;
  localparam int MODE_CSLOW_BIT = 6;
  localparam int MODE_DSLOW_BIT = 5;
  // clear_register fields
  localparam int CLR_CHG = 0;
  localparam int CLR_DSG = 1;
  localparam int CLR_SD = 2;
  localparam int CLR_CT = 3;
  localparam int CLR_DT = 4;
  localparam logic [4:0] CLR_ALL = 5'h1f;
  // command codes
  localparam logic [7:0] CMD_SLEEP = 8'h01;
  localparam logic [7:0] CMD_RESET = 8'h02;
  localparam logic [7:0] CMD_PROGRAM = 8'h04;
  localparam logic [7:0] CMD_RECALL = 8'h08;
  // reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
endpackage : cc_pkg

/* hw/cc_counters.sv */
`timescale 1ns/100ps
`default_nettype none
module cc_counters
  import cc_pkg::*;
#(
  parameter int unsigned TIME_TICK_CYCLES_P = cc_pkg::TIME_TICK_CYCLES,
  parameter int unsigned OFS_LSB_CYCLES_P = cc_pkg::OFS_LSB_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic VFC_PULSE,
  input wire logic VFC_NEGATIVE,
  input wire logic [8:0] TEMP_KELVIN,
  input wire logic LINK_ACTIVITY,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WRITE,
  output logic [7:0] REG_RDATA,
  output logic REGULATOR_ENABLE,
  output logic SLEEP_ACTIVE,
  output logic FLASH_PROGRAM_REQ,
  output logic FLASH_RECALL_REQ
);
  typedef struct packed {
    logic [15:0] chg;
    logic [15:0] dsg;
    logic [15:0] sd;
    logic [15:0] ctime;
    logic [15:0] dtime;
    logic [7:0] cpre;
    logic [7:0] dpre;
    logic cslow;
    logic dslow;
    logic cseen;
    logic dseen;
    logic [SD_PRE_W-1:0] sd_pre;
    logic [TICK_W-1:0] tick_cnt;
    logic [OFS_PRE_W-1:0] ofs_pre;
    logic [OFS_W-1:0] ofs_cnt;
    logic [7:0] ofs_hi;
    logic [7:0] ofs_mid;
    logic [7:0] ofs_lo;
    logic reg_dis;
    logic [4:0] clr;
    logic sleep;
    logic prog;
    logic recall;
    logic pulse_prev;
    logic [7:0] rdata;
  } cc_state_t;

  cc_state_t st_reg;
  cc_state_t st_next;
  logic [1:0] vfc_sync;
  logic tick;
  logic pulse;
  logic pulse_chg;
  logic pulse_dsg;
  logic comp;
  logic comp_chg;
  logic comp_dsg;
  logic ct_inc;
  logic dt_inc;
  logic sd_inc;
  logic [OFS_W-1:0] ofs_value;

  // pulse and polarity come from the analog converter, off this clock
  cc_sync #(.W(2)) u_sync (
    .SYS_CLK(SYS_CLK),
    .RESET(RESET),
    .ASYNC_IN({VFC_NEGATIVE, VFC_PULSE}),
    .SYNC_OUT(vfc_sync)
  );

  // self-discharge period in time ticks for a die temperature
  function automatic logic [SD_PRE_W-1:0] sd_period(input logic [8:0] kelvin);
    int tc;
    int up;
    int down;
    tc = int'(kelvin) - int'(KELVIN_ZERO_C);
    if (tc > SD_HIGH_C) tc = SD_HIGH_C;
    if (tc < SD_LOW_C) tc = SD_LOW_C;
    up = 0;
    down = 0;
    if (tc >= SD_BASE_C) up = (tc - SD_BASE_C) / SD_STEP_C;
    else down = (SD_BASE_C - tc + SD_STEP_C - 1) / SD_STEP_C;
    sd_period = (SD_TICKS_PER_HOUR << down) >> up;
  endfunction : sd_period

  // one step of a time counter: fires on a tick of matching activity
  function automatic logic time_step(input logic act, input logic slow,
                                     input logic [7:0] pre, input logic tk);
    time_step = tk && act && (!slow || pre == SLOW_PRE_LAST);
  endfunction : time_step

  // event decode used by the update and by the checks
  assign ofs_value = {st_reg.ofs_hi[5:0], st_reg.ofs_mid, st_reg.ofs_lo};
  assign tick = (st_reg.tick_cnt == TICK_W'(TIME_TICK_CYCLES_P - 1));
  assign pulse = vfc_sync[0] && !st_reg.pulse_prev && !st_reg.sleep;
  assign pulse_chg = pulse && !vfc_sync[1];
  assign pulse_dsg = pulse && vfc_sync[1];
  assign comp = st_reg.ofs_hi[OFS_OFFSET_COMP_ENABLE_BIT] && !st_reg.sleep && ofs_value != '0
    && st_reg.ofs_pre == OFS_PRE_W'(OFS_LSB_CYCLES_P - 1)
    && st_reg.ofs_cnt + OFS_W'(1) >= ofs_value;
  assign comp_chg = comp && st_reg.ofs_hi[OFS_DIR_BIT];
  assign comp_dsg = comp && !st_reg.ofs_hi[OFS_DIR_BIT];
  assign ct_inc = !st_reg.sleep
    && time_step(st_reg.cseen || pulse_chg, st_reg.cslow, st_reg.cpre, tick);
  assign dt_inc = !st_reg.sleep
    && time_step(st_reg.dseen || pulse_dsg, st_reg.dslow, st_reg.dpre, tick);
  assign sd_inc = tick && st_reg.sd_pre + SD_PRE_W'(1) >= sd_period(TEMP_KELVIN);

  // next-state logic; a clear zeroes the base so a same-cycle count survives
  always_comb begin
    st_next = st_reg;
    st_next.pulse_prev = vfc_sync[0];
    st_next.prog = 1'b0;
    st_next.recall = 1'b0;
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + TICK_W'(1);
    // charge and discharge counts: pulses plus compensation
    st_next.chg = (st_reg.clr[CLR_CHG] ? COUNT_RST : st_reg.chg)
      + {15'h0000, pulse_chg} + {15'h0000, comp_chg};
    st_next.dsg = (st_reg.clr[CLR_DSG] ? COUNT_RST : st_reg.dsg)
      + {15'h0000, pulse_dsg} + {15'h0000, comp_dsg};
    // activity seen since the last tick decides which time counter runs
    st_next.cseen = pulse_chg || (st_reg.cseen && !tick);
    st_next.dseen = pulse_dsg || (st_reg.dseen && !tick);
    // charge time counter with slow-rate prescaler
    if (tick && (st_reg.cseen || pulse_chg) && st_reg.cslow && !st_reg.sleep) begin
      st_next.cpre = st_reg.cpre + 8'h01;
    end
    st_next.ctime = (st_reg.clr[CLR_CT] ? COUNT_RST : st_reg.ctime) + {15'h0000, ct_inc};
    st_next.cslow = (st_reg.cslow && !st_reg.clr[CLR_CT])
      || (ct_inc && st_reg.ctime == COUNT_MAX && !st_reg.clr[CLR_CT]);
    if (st_reg.clr[CLR_CT]) st_next.cpre = BYTE_RST;
    // discharge time counter with slow-rate prescaler
    if (tick && (st_reg.dseen || pulse_dsg) && st_reg.dslow && !st_reg.sleep) begin
      st_next.dpre = st_reg.dpre + 8'h01;
    end
    st_next.dtime = (st_reg.clr[CLR_DT] ? COUNT_RST : st_reg.dtime) + {15'h0000, dt_inc};
    st_next.dslow = (st_reg.dslow && !st_reg.clr[CLR_DT])
      || (dt_inc && st_reg.dtime == COUNT_MAX && !st_reg.clr[CLR_DT]);
    if (st_reg.clr[CLR_DT]) st_next.dpre = BYTE_RST;
    // self-discharge keeps counting in sleep
    if (tick) st_next.sd_pre = sd_inc ? '0 : st_reg.sd_pre + SD_PRE_W'(1);
    st_next.sd = (st_reg.clr[CLR_SD] ? COUNT_RST : st_reg.sd) + {15'h0000, sd_inc};
    // offset compensation interval, in 9.76 ms steps
    if (!st_reg.ofs_hi[OFS_OFFSET_COMP_ENABLE_BIT] || st_reg.sleep) begin
      st_next.ofs_pre = '0;
      st_next.ofs_cnt = '0;
    end else if (st_reg.ofs_pre == OFS_PRE_W'(OFS_LSB_CYCLES_P - 1)) begin
      st_next.ofs_pre = '0;
      st_next.ofs_cnt = comp ? '0 : st_reg.ofs_cnt + OFS_W'(1);
    end else begin
      st_next.ofs_pre = st_reg.ofs_pre + OFS_PRE_W'(1);
    end
    // clear bits act for one cycle then drop
    st_next.clr = 5'h00;
    // wake on any link activity; a sleep command in the same cycle wins
    if (LINK_ACTIVITY) st_next.sleep = 1'b0;
    // register writes from the link engine
    if (REG_WRITE) begin
      case (REG_ADDR)
        ADDR_OFS_HI: st_next.ofs_hi = REG_WDATA;
        ADDR_OFS_MID: st_next.ofs_mid = REG_WDATA;
        ADDR_OFS_LO: st_next.ofs_lo = REG_WDATA;
        ADDR_MODE: st_next.reg_dis = REG_WDATA[MODE_REGDIS_BIT];
        ADDR_CLR: st_next.clr = REG_WDATA[4:0];
        ADDR_CMD: begin
          case (REG_WDATA)
            CMD_SLEEP: st_next.sleep = 1'b1;
            CMD_RESET: st_next.clr = CLR_ALL;
            CMD_PROGRAM: st_next.prog = 1'b1;
            CMD_RECALL: st_next.recall = 1'b1;
            default: st_next.prog = 1'b0;
          endcase
        end
        default: st_next.rdata = st_next.rdata;
      endcase
    end
    // read data is registered from the current address
    case (REG_ADDR)
      ADDR_OFS_HI: st_next.rdata = st_reg.ofs_hi;
      ADDR_OFS_MID: st_next.rdata = st_reg.ofs_mid;
      ADDR_OFS_LO: st_next.rdata = st_reg.ofs_lo;
      ADDR_DSG_H: st_next.rdata = st_reg.dsg[15:8];
      ADDR_DSG_L: st_next.rdata = st_reg.dsg[7:0];
      ADDR_CHG_H: st_next.rdata = st_reg.chg[15:8];
      ADDR_CHG_L: st_next.rdata = st_reg.chg[7:0];
      ADDR_SD_H: st_next.rdata = st_reg.sd[15:8];
      ADDR_SD_L: st_next.rdata = st_reg.sd[7:0];
      ADDR_DT_H: st_next.rdata = st_reg.dtime[15:8];
      ADDR_DT_L: st_next.rdata = st_reg.dtime[7:0];
      ADDR_CT_H: st_next.rdata = st_reg.ctime[15:8];
      ADDR_CT_L: st_next.rdata = st_reg.ctime[7:0];
      ADDR_MODE: st_next.rdata = {st_reg.reg_dis, st_reg.cslow, st_reg.dslow, 5'h00};
      ADDR_CLR: st_next.rdata = {3'h0, st_reg.clr};
      default: st_next.rdata = BYTE_RST;
    endcase
  end

  // single state register; everything resets to zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // the regulator ignores sleep, only the disable bit turns it off
  assign REGULATOR_ENABLE = !st_reg.reg_dis;
  assign SLEEP_ACTIVE = st_reg.sleep;
  assign FLASH_PROGRAM_REQ = st_reg.prog;
  assign FLASH_RECALL_REQ = st_reg.recall;
  assign REG_RDATA = st_reg.rdata;

  // checks
  sequence s_clr_write(int b);
    REG_WRITE && REG_ADDR == ADDR_CLR && REG_WDATA[b];
  endsequence

  sequence s_clr_done(int b);
    st_reg.clr[b] ##1 !st_reg.clr[b];
  endsequence

  property p_chg_pulse;
    @(posedge SYS_CLK) disable iff (RESET)
      pulse_chg && !comp && !st_reg.clr[CLR_CHG] |=> st_reg.chg == $past(st_reg.chg) + 16'h0001;
  endproperty
  a_chg_pulse: assert property (p_chg_pulse) else $error("charge pulse not counted");

  property p_dsg_pulse;
    @(posedge SYS_CLK) disable iff (RESET)
      pulse_dsg && !comp && !st_reg.clr[CLR_DSG] |=> st_reg.dsg == $past(st_reg.dsg) + 16'h0001;
  endproperty
  a_dsg_pulse: assert property (p_dsg_pulse) else $error("discharge pulse not counted");

  property p_one_side;
    @(posedge SYS_CLK) disable iff (RESET)
      pulse_chg && !comp && !st_reg.clr[CLR_DSG] |=> $stable(st_reg.dsg);
  endproperty
  a_one_side: assert property (p_one_side) else $error("discharge moved on charge");

  property p_idle_hold;
    @(posedge SYS_CLK) disable iff (RESET)
      !pulse && !comp && st_reg.clr == 5'h00 |=> $stable(st_reg.chg) && $stable(st_reg.dsg);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved without pulse");

  property p_wrap;
    @(posedge SYS_CLK) disable iff (RESET)
      dt_inc && st_reg.dtime == COUNT_MAX && !st_reg.clr[CLR_DT]
      |=> st_reg.dtime == COUNT_RST && st_reg.dslow;
  endproperty
  a_wrap: assert property (p_wrap) else $error("discharge time wrap missed slow flag");

  property p_slow_hold;
    @(posedge SYS_CLK) disable iff (RESET)
      st_reg.cslow && st_reg.cpre != SLOW_PRE_LAST && !st_reg.clr[CLR_CT]
      |=> $stable(st_reg.ctime);
  endproperty
  a_slow_hold: assert property (p_slow_hold) else $error("slow counter stepped early");

  property p_time_tick;
    @(posedge SYS_CLK) disable iff (RESET)
      !tick && !st_reg.clr[CLR_CT] && !st_reg.clr[CLR_DT]
      |=> $stable(st_reg.ctime) && $stable(st_reg.dtime);
  endproperty
  a_time_tick: assert property (p_time_tick) else $error("time count off tick");

  property p_sd_tick;
    @(posedge SYS_CLK) disable iff (RESET)
      !tick && !st_reg.clr[CLR_SD] |=> $stable(st_reg.sd);
  endproperty
  a_sd_tick: assert property (p_sd_tick) else $error("self-discharge stepped off tick");

  property p_clear(int b);
    @(posedge SYS_CLK) disable iff (RESET)
      s_clr_write(b) |=> s_clr_done(b);
  endproperty
  a_clear: assert property (p_clear(CLR_CHG)) else $error("clear bit stuck");

  property p_clear_zero;
    @(posedge SYS_CLK) disable iff (RESET)
      st_reg.clr[CLR_SD] |=> st_reg.sd <= 16'h0001;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear missed target");

  property p_comp;
    @(posedge SYS_CLK) disable iff (RESET)
      comp_dsg && !pulse && !st_reg.clr[CLR_DSG] |=> st_reg.dsg == $past(st_reg.dsg) + 16'h0001;
  endproperty
  a_comp: assert property (p_comp) else $error("compensation count lost");

  property p_reg_sleep;
    @(posedge SYS_CLK) disable iff (RESET)
      st_reg.sleep && !st_reg.reg_dis |-> REGULATOR_ENABLE;
  endproperty
  a_reg_sleep: assert property (p_reg_sleep) else $error("regulator off in sleep");

  property p_sleep_cmd;
    @(posedge SYS_CLK) disable iff (RESET)
      REG_WRITE && REG_ADDR == ADDR_CMD && REG_WDATA == CMD_SLEEP |=> SLEEP_ACTIVE;
  endproperty
  a_sleep_cmd: assert property (p_sleep_cmd) else $error("sleep command ignored");

  property p_comp_chg;
    @(posedge SYS_CLK) disable iff (RESET)
      comp_chg && !pulse && !st_reg.clr[CLR_CHG] |=> st_reg.chg == $past(st_reg.chg) + 16'h0001;
  endproperty
  a_comp_chg: assert property (p_comp_chg) else $error("charge compensation lost");

  // in sleep only self-discharge may move; pulses, time and compensation freeze
  property p_sleep_hold;
    @(posedge SYS_CLK) disable iff (RESET)
      st_reg.sleep && st_reg.clr == 5'h00
      |=> $stable(st_reg.chg) && $stable(st_reg.dsg) && $stable(st_reg.ctime)
      && $stable(st_reg.dtime);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

  // the disable bit lands on the regulator output one cycle after the write
  property p_reg_dis;
    @(posedge SYS_CLK) disable iff (RESET)
      REG_WRITE && REG_ADDR == ADDR_MODE
      |=> REGULATOR_ENABLE == !$past(REG_WDATA[MODE_REGDIS_BIT]);
  endproperty
  a_reg_dis: assert property (p_reg_dis) else $error("regulator bit not applied");
endmodule : cc_counters
`default_nettype wire

/* hw/cc_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for asynchronous levels
module cc_sync #(
  parameter int W = 2
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [W-1:0] ASYNC_IN,
  output logic [W-1:0] SYNC_OUT
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= ASYNC_IN;
      sync_reg <= meta_reg;
    end
  end

  assign SYNC_OUT = sync_reg;
endmodule : cc_sync
`default_nettype wire

/* testbench/cc_counters_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module cc_counters_tb_top;
  import cc_pkg::*;
  localparam int unsigned TT = 20; // short time tick keeps the run small
  localparam int unsigned OL = 4;
  logic sys_clk, reset, vfc_pulse, vfc_negative, link_activity;
  logic [8:0] temp_kelvin;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, b;
  logic reg_write, reg_en, sleep_act, flash_prog, flash_rec;
  logic [15:0] v, v0;
  int n_fail = 0;
  int check_count = 0;
  int n, m, ofs;
  logic [6:0] cnt_lo [5] = '{ADDR_DSG_L, ADDR_CHG_L, ADDR_SD_L, ADDR_DT_L, ADDR_CT_L};

  cc_counters #(.TIME_TICK_CYCLES_P(TT), .OFS_LSB_CYCLES_P(OL)) uut (
    .SYS_CLK(sys_clk), .RESET(reset), .VFC_PULSE(vfc_pulse), .VFC_NEGATIVE(vfc_negative),
    .TEMP_KELVIN(temp_kelvin), .LINK_ACTIVITY(link_activity), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WRITE(reg_write), .REG_RDATA(reg_rdata),
    .REGULATOR_ENABLE(reg_en), .SLEEP_ACTIVE(sleep_act),
    .FLASH_PROGRAM_REQ(flash_prog), .FLASH_RECALL_REQ(flash_rec));
  cc_host_model host (
    .SYS_CLK(sys_clk), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WRITE(reg_write), .REG_RDATA(reg_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // expected self-discharge period in ticks, temperature clamped to its limits
  function automatic int sd_ticks(input int c);
    int t;
    t = (c > SD_HIGH_C) ? SD_HIGH_C : ((c < SD_LOW_C) ? SD_LOW_C : c);
    if (t >= SD_BASE_C) return 4096 >> ((t - SD_BASE_C) / SD_STEP_C);
    return 4096 << ((SD_BASE_C - t + SD_STEP_C - 1) / SD_STEP_C);
  endfunction : sd_ticks

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // range compare for counts whose phase against the timebase is loose
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    check_count++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t got %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic rd16(input logic [6:0] a, output logic [15:0] r);
    logic [7:0] l, h;
    host.rd(a, l);
    host.rd(a + 7'h01, h); // high byte sits one above the low byte
    r = {h, l};
  endtask : rd16

  // polarity settles well before the edges and stays put around them
  task automatic pulse(input logic neg, input int k);
    vfc_negative <= neg;
    repeat (4) @(posedge sys_clk);
    repeat (k) begin
      vfc_pulse <= 1'b1;
      repeat (2) @(posedge sys_clk);
      vfc_pulse <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk); // synchroniser drain
  endtask : pulse

  // a request output must pulse exactly once, the other never
  task automatic flash_cmd(input logic [7:0] cmd);
    int hp, hr;
    hp = 0;
    hr = 0;
    host.wr(ADDR_CMD, cmd);
    repeat (4) begin
      #1;
      hp += int'(flash_prog === 1'b1);
      hr += int'(flash_rec === 1'b1);
      @(posedge sys_clk);
    end
    chk(16'(hp), {15'h0000, cmd == CMD_PROGRAM});
    chk(16'(hr), {15'h0000, cmd == CMD_RECALL});
  endtask : flash_cmd

  initial begin
    #(60_000 * CLK_PERIOD_NS);
    n_fail++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    vfc_pulse = 1'b0;
    vfc_negative = 1'b0;
    link_activity = 1'b0;
    temp_kelvin = 9'h12a; // 25 C
    void'($urandom(32'h90f9fbc2));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    // quiet after reset: all counts zero, regulator on, awake
    foreach (cnt_lo[i]) begin
      rd16(cnt_lo[i], v);
      chk(v, COUNT_RST);
    end
    chk({15'h0000, reg_en}, 16'h0001);
    chk({15'h0000, sleep_act}, 16'h0000);
    host.rd(7'h70, b);
    chk({8'h00, b}, 16'h0000);
    host.wr(ADDR_CHG_L, 8'h55); // read-only place ignores writes
    rd16(ADDR_CHG_L, v);
    chk(v, 16'h0000);
    // charge then discharge bursts, random lengths
    n = 3 + $urandom % 8;
    m = 3 + $urandom % 8;
    host.slow = 2;
    pulse(1'b0, n);
    rd16(ADDR_CHG_L, v);
    chk(v, 16'(n));
    rd16(ADDR_DSG_L, v);
    chk(v, 16'h0000);
    rd16(ADDR_CT_L, v);
    chk_rng(v, 1, 4 * n / TT + 2);
    rd16(ADDR_DT_L, v);
    chk(v, 16'h0000);
    host.slow = 0;
    pulse(1'b1, m);
    rd16(ADDR_DSG_L, v);
    chk(v, 16'(m));
    rd16(ADDR_DT_L, v);
    chk_rng(v, 1, 4 * m / TT + 2);
    repeat (200) @(posedge sys_clk);
    rd16(ADDR_CHG_L, v);
    chk(v, 16'(n));
    // clear bits zero their target and fall back by themselves
    host.wr(ADDR_CLR, 8'h01 << CLR_CHG);
    host.rd(ADDR_CLR, b);
    chk({8'h00, b}, 16'h0000);
    rd16(ADDR_CHG_L, v);
    chk(v, 16'h0000);
    rd16(ADDR_DSG_L, v);
    chk(v, 16'(m));
    host.wr(ADDR_CLR, (8'h01 << CLR_CT) | (8'h01 << CLR_DT));
    rd16(ADDR_DT_L, v);
    chk(v, 16'h0000);
    // regulator off by mode bit, then on again and kept on through sleep
    host.wr(ADDR_MODE, 8'h80);
    host.rd(ADDR_MODE, b);
    chk({8'h00, b}, 16'h0080);
    chk({15'h0000, reg_en}, 16'h0000);
    host.wr(ADDR_MODE, 8'h00);
    host.wr(ADDR_CMD, CMD_SLEEP);
    #1;
    chk({15'h0000, sleep_act}, 16'h0001);
    chk({15'h0000, reg_en}, 16'h0001);
    pulse(1'b0, 3); // ignored while asleep
    link_activity <= 1'b1;
    @(posedge sys_clk);
    link_activity <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, sleep_act}, 16'h0000);
    rd16(ADDR_CHG_L, v);
    chk(v, 16'h0000);
    flash_cmd(CMD_PROGRAM);
    flash_cmd(CMD_RECALL);
    host.wr(ADDR_CMD, CMD_RESET);
    rd16(ADDR_DSG_L, v);
    chk(v, 16'h0000);
    // offset compensation: charge side, then discharge side
    ofs = 2 + $urandom % 6;
    host.wr(ADDR_OFS_LO, 8'(ofs));
    host.wr(ADDR_OFS_MID, 8'h00);
    host.wr(ADDR_OFS_HI, 8'hc0);
    host.rd(ADDR_OFS_LO, b);
    chk({8'h00, b}, 16'(ofs));
    host.rd(ADDR_OFS_HI, b);
    chk({8'h00, b}, 16'h00c0);
    for (int d = 0; d < 2; d++) begin
      rd16((d == 0) ? ADDR_CHG_L : ADDR_DSG_L, v0);
      repeat (400) @(posedge sys_clk);
      rd16((d == 0) ? ADDR_CHG_L : ADDR_DSG_L, v);
      chk_rng(v - v0, 400 / (ofs * OL) - 1, 408 / (ofs * OL) + 1);
      host.wr(ADDR_OFS_HI, 8'h80); // direction now discharge
    end
    host.wr(ADDR_OFS_HI, 8'h00);
    rd16(ADDR_CHG_L, v0);
    repeat (100) @(posedge sys_clk);
    rd16(ADDR_CHG_L, v);
    chk(v, v0);
    // self-discharge at 70 C runs at the 60 C limit rate
    temp_kelvin <= 9'h157;
    host.wr(ADDR_CLR, 8'h01 << CLR_SD);
    repeat (25600) @(posedge sys_clk);
    rd16(ADDR_SD_L, v);
    n = 25600 / (sd_ticks(70) * TT);
    chk_rng(v, n - 1, n + 1);
    final_report();
  end
endmodule : cc_counters_tb_top
`default_nettype wire

/* testbench/cc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// host end of the register link: one request at a time, strobes held one full cycle
module cc_host_model (
  input wire logic SYS_CLK,
  output logic [6:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WRITE,
  input wire logic [7:0] REG_RDATA
);
  int slow = 0; // idle cycles before each request, so the host can act slowly
  initial begin
    REG_ADDR = 7'h00;
    REG_WDATA = 8'h00;
    REG_WRITE = 1'b0;
  end
  // one clean strobe per write, dropped again at the next edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    repeat (slow) @(posedge SYS_CLK);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WRITE <= 1'b1;
    @(posedge SYS_CLK);
    REG_WRITE <= 1'b0;
    REG_WDATA <= ~d; // released data shows the inverse so a stale byte cannot pass
  endtask : wr
  // address taken at the next edge, registered answer sampled just after it
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    repeat (slow) @(posedge SYS_CLK);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    #1 d = REG_RDATA;
  endtask : rd
endmodule : cc_host_model
`default_nettype wire
